// File: verilog/rwt_restart_timer.sv
// rwt_restart_timer: restart watchdog, interval timer and boot source selection.
// assumes i/o command strobes come from processor logic on mclk_i; switches,
// straps, console lines and the keyboard-clear strobe come from pins.
`timescale 1ns/100ps

module rwt_restart_timer (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic kbd_clear_i,
  input wire logic console_stop_i,
  input wire logic console_single_i,
  input wire logic manual_disable_i,
  input wire logic interval_enable_i,
  input wire logic boot_button_i,
  input wire logic [1:0] power_status_i,
  input wire logic warn_patch_i,
  input wire logic dual_boot_patch_i,
  input wire logic load_source_switch_i,
  input wire logic alt_load_switch_i,
  input wire logic [2:0] alt_port_i,
  input wire logic [1:0] alt_subchan_i,
  input wire logic io_out_i,
  input wire logic io_start_mode_i,
  input wire logic io_status_rd_i,
  input wire logic [11:0] io_dev_addr_i,
  input wire logic interval_ack_i,
  output logic [1:0] status_data_o,
  output logic status_valid_o,
  output logic stop_line_o,
  output logic io_reset_o,
  output logic cpu_reset_o,
  output logic boot_start_o,
  output logic boot_remote_o,
  output logic [4:0] load_addr_o,
  output logic [7:0] config_byte_o,
  output logic warn_irq_o,
  output logic interval_irq_o,
  output logic timer_running_o,
  output logic [9:0] count_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] async_in; // gathered pin levels
  logic [7:0] sync1_r; // first stage, read only by sync2_r
  logic [7:0] sync2_r; // second stage
  logic [7:0] sync3_r; // third stage
  logic [7:0] stable_r; // level accepted once stages two and three agree

  assign async_in = {power_status_i[1], power_status_i[0], boot_button_i,
                     interval_enable_i, manual_disable_i, console_single_i,
                     console_stop_i, kbd_clear_i};

  // one flop chain per pin; a level only counts after two stages agree,
  // which filters a single metastable resolution
  genvar gi;
  generate
    for (gi = 0; gi < rwt_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          stable_r[gi] <= 1'b0;
        end else if (clk_en_i) begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            stable_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  logic kbd_prev_r; // last accepted strobe level
  logic btn_prev_r; // last accepted boot button level
  wire kbd_lvl = stable_r[rwt_pkg::S_KBD];
  wire kbd_pulse = kbd_lvl & ~kbd_prev_r; // one cycle per strobe
  wire btn_lvl = stable_r[rwt_pkg::S_BOOTBTN];
  wire btn_pulse = btn_lvl & ~btn_prev_r; // one cycle per press
  wire stop_mode = stable_r[rwt_pkg::S_STOP];
  wire stop_line = stop_mode | stable_r[rwt_pkg::S_SINGLE];
  wire man_dis = stable_r[rwt_pkg::S_MANDIS];
  wire iv_switch = stable_r[rwt_pkg::S_IVEN];
  wire addr_hit = (io_dev_addr_i == rwt_pkg::TIMER_DEV_ADDR);
  // effective address of the output command plays no part here
  wire cmd_start = io_out_i & addr_hit & io_start_mode_i;
  wire cmd_stop = io_out_i & addr_hit & ~io_start_mode_i;
  wire status_rd = io_status_rd_i & addr_hit;

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  logic [9:0] count_r; // strobes since last clear
  logic [9:0] count_nxt;
  logic run_r; // program run/stop state of the timer
  logic run_nxt;
  logic boot_r; // boot load issued last cycle, clears the counter
  logic timeout; // counter reaches its end this cycle
  logic hold; // any of the disabling conditions
  logic clear; // any clear that lets counting go on

  assign hold = ~run_r | stop_line | man_dis;
  assign clear = status_rd | cmd_start | boot_r;
  assign timeout = kbd_pulse & ~hold & ~clear &
                   (count_r == rwt_pkg::TIMEOUT_COUNT - 10'h001);

  // run state: stop command holds, start command releases
  always_comb begin
    run_nxt = run_r;
    if (cmd_stop) begin
      run_nxt = 1'b0;
    end else if (cmd_start) begin
      run_nxt = 1'b1;
    end
  end

  // clears take precedence over a strobe in the same cycle, so a
  // status read can never be overtaken by a late step
  always_comb begin
    count_nxt = count_r;
    if (hold | cmd_stop) begin
      count_nxt = rwt_pkg::COUNT_ZERO;
    end else if (clear | timeout) begin
      count_nxt = rwt_pkg::COUNT_ZERO;
    end else if (kbd_pulse) begin
      count_nxt = count_r + 10'h001;
    end
  end

  // counter, run state and edge history
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      count_r <= rwt_pkg::COUNT_ZERO;
      run_r <= 1'b1;
      kbd_prev_r <= 1'b0;
      btn_prev_r <= 1'b0;
    end else if (clk_en_i) begin
      count_r <= count_nxt;
      run_r <= run_nxt;
      kbd_prev_r <= kbd_lvl;
      btn_prev_r <= btn_lvl;
    end
  end

  // ----------------------------------------------------------------
  // restart, boot select and load address
  // ----------------------------------------------------------------
  logic restart_r; // one-cycle reset request to i/o and cpu
  logic boot_remote_r; // image source of the current boot
  logic [4:0] load_addr_r; // device the boot reads from
  logic boot_go; // any boot trigger this cycle
  logic remote_sel; // source for this trigger
  logic dual_cmd; // output command that forces a remote boot
  logic [4:0] alt_addr; // alternate address from the switches
  logic [2:0] port_lim; // port clamped to the legal range

  assign dual_cmd = dual_boot_patch_i & io_out_i & addr_hit;
  assign boot_go = timeout | btn_pulse | dual_cmd;
  // pushbutton and timeout follow the switch even with the patch
  assign remote_sel = dual_cmd ? 1'b1 : load_source_switch_i;
  // port 7 is not a legal alternate; treat it as the highest port
  assign port_lim = (alt_port_i > rwt_pkg::PORT_MAX) ? rwt_pkg::PORT_MAX : alt_port_i;
  assign alt_addr = {port_lim, alt_subchan_i};

  // restart is a single pulse; the counter was already zeroed by timeout
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      restart_r <= 1'b0;
      boot_r <= 1'b0;
      boot_remote_r <= 1'b0;
      load_addr_r <= rwt_pkg::PRIMARY_LOAD_ADDR;
    end else if (clk_en_i) begin
      restart_r <= timeout;
      boot_r <= boot_go;
      if (boot_go) begin
        boot_remote_r <= remote_sel;
        load_addr_r <= alt_load_switch_i ? alt_addr : rwt_pkg::PRIMARY_LOAD_ADDR;
      end
    end
  end

  // ----------------------------------------------------------------
  // warning and interval interrupts
  // ----------------------------------------------------------------
  logic warn_r; // warning level, drops when the counter clears
  logic iv_pend_r; // single pending interval request
  logic iv_set; // interval request raised this cycle

  // interval strobe suppressed by the switch or console stop
  assign iv_set = kbd_pulse & iv_switch & ~stop_mode;

  // the processor's own gating decides when iv is taken; the request
  // simply waits here until acknowledged
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      warn_r <= 1'b0;
      iv_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      warn_r <= warn_patch_i & count_nxt[rwt_pkg::WARN_BIT];
      if (iv_set) begin
        iv_pend_r <= 1'b1;
      end else if (interval_ack_i) begin
        iv_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status read and configuration byte
  // ----------------------------------------------------------------
  logic [1:0] status_r; // power lines caught at the read
  logic status_vld_r; // one-cycle answer strobe
  logic [7:0] cfg_r; // first configuration byte

  // the read both clears the counter and samples the power lines
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      status_r <= rwt_pkg::PWR_RESET;
      status_vld_r <= 1'b0;
      cfg_r <= rwt_pkg::CFG_RESET;
    end else if (clk_en_i) begin
      status_vld_r <= status_rd;
      if (status_rd) begin
        status_r <= {stable_r[rwt_pkg::S_PWR1], stable_r[rwt_pkg::S_PWR0]};
      end
      cfg_r[rwt_pkg::CFG_ALT_FLAG_BIT] <= alt_load_switch_i;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign status_data_o = status_r;
  assign status_valid_o = status_vld_r;
  assign stop_line_o = stop_line;
  assign io_reset_o = restart_r;
  assign cpu_reset_o = restart_r;
  assign boot_start_o = boot_r;
  assign boot_remote_o = boot_remote_r;
  assign load_addr_o = load_addr_r;
  assign config_byte_o = cfg_r;
  assign warn_irq_o = warn_r;
  assign interval_irq_o = iv_pend_r;
  assign timer_running_o = ~hold;
  assign count_o = count_r;

endmodule

// File: include/rwt_pkg.sv
// rwt_pkg: constants for the restart watchdog and interval timer.
// assumes keyboard-clear strobes arrive at a slow fixed rate from a display adapter.
package rwt_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000; // mclk_i rate
  localparam int unsigned KBD_PULSE_HZ = 15; // keyboard-clear strobe rate
  localparam int unsigned KBD_PERIOD_MS = 67; // interval interrupt spacing
  localparam int unsigned CNT_W = 10; // holds 2**9 with one spare bit
  localparam logic [9:0] TIMEOUT_COUNT = 10'h200; // 2**9 strobes, about 34.13 s
  localparam logic [9:0] WARN_COUNT = 10'h100; // 2**8 strobes, about 17.07 s
  localparam logic [9:0] COUNT_ZERO = 10'h000;
  localparam int unsigned WARN_BIT = 8; // count bit that marks the warning point
  // ----------------------------------------------------------------
  // i/o addressing
  // ----------------------------------------------------------------
  localparam int unsigned DEV_ADDR_W = 12;
  localparam logic [11:0] TIMER_DEV_ADDR = 12'hDF0;
  localparam int unsigned PWR_W = 2;
  localparam logic [1:0] PWR_RESET = 2'h0;
  // ----------------------------------------------------------------
  // boot load address: {port[2:0], subchannel[1:0]}
  // ----------------------------------------------------------------
  localparam int unsigned LOAD_ADDR_W = 5;
  localparam int unsigned SUBCH_W = 2;
  localparam int unsigned PORT_W = 3;
  localparam int unsigned SUBCH_LSB = 0;
  localparam int unsigned PORT_LSB = 2;
  localparam logic [4:0] PRIMARY_LOAD_ADDR = 5'h00; // multiplex channel zero
  localparam logic [2:0] PORT_MAX = 3'h6; // highest legal alternate port
  localparam int unsigned CFG_ALT_FLAG_BIT = 0; // flag bit in first config byte
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ----------------------------------------------------------------
  // asynchronous inputs sent through the three-stage synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 8;
  localparam int unsigned S_KBD = 0;
  localparam int unsigned S_STOP = 1;
  localparam int unsigned S_SINGLE = 2;
  localparam int unsigned S_MANDIS = 3;
  localparam int unsigned S_IVEN = 4;
  localparam int unsigned S_BOOTBTN = 5;
  localparam int unsigned S_PWR0 = 6;
  localparam int unsigned S_PWR1 = 7;
endpackage

// File: tb/rwt_chk.sv
// rwt_chk: port-level checks for the restart watchdog and interval timer.
// assumes one mclk_i domain with synchronous reset_i.
`timescale 1ns/100ps
module rwt_chk (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic io_status_rd_i,
  input wire logic [11:0] io_dev_addr_i,
  input wire logic [1:0] power_status_i,
  input wire logic status_valid_o,
  input wire logic [1:0] status_data_o,
  input wire logic [9:0] count_o,
  input wire logic io_reset_o,
  input wire logic cpu_reset_o,
  input wire logic boot_start_o,
  input wire logic warn_patch_i,
  input wire logic warn_irq_o,
  input wire logic stop_line_o,
  input wire logic interval_irq_o,
  input wire logic interval_ack_i,
  input wire logic alt_load_switch_i,
  input wire logic [7:0] config_byte_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // a status read that hits the timer address
  wire hit = io_status_rd_i && io_dev_addr_i == rwt_pkg::TIMER_DEV_ADDR;
  sequence s_read; hit; endsequence
  // power lines quiet long enough to clear the synchroniser
  sequence s_quiet; $stable(power_status_i)[*6]; endsequence
  property p_read; s_read |=> status_valid_o && count_o == 10'h000; endproperty
  a_read: assert property (p_read) else $error("status read not answered");
  property p_miss; io_status_rd_i && !hit |=> !status_valid_o; endproperty
  a_miss: assert property (p_miss) else $error("foreign address answered");
  property p_pwr; s_quiet ##0 s_read |=> status_data_o == $past(power_status_i); endproperty
  a_pwr: assert property (p_pwr) else $error("power lines wrong");
  property p_step; $changed(count_o) |-> count_o == $past(count_o) + 10'h001 || count_o == 10'h000; endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_tmo; io_reset_o |-> cpu_reset_o && boot_start_o && $past(count_o, 2) == 10'h1FF; endproperty
  a_tmo: assert property (p_tmo) else $error("restart without timeout");
  property p_once; io_reset_o |=> !io_reset_o && count_o == 10'h000; endproperty
  a_once: assert property (p_once) else $error("restart not single");
  property p_warn; (warn_patch_i && count_o >= 10'h100)[*2] |-> warn_irq_o; endproperty
  a_warn: assert property (p_warn) else $error("warning missing");
  property p_nowarn; (!warn_patch_i || count_o < 10'h100)[*2] |-> !warn_irq_o; endproperty
  a_nowarn: assert property (p_nowarn) else $error("warning early");
  property p_hold; stop_line_o[*3] |-> count_o == 10'h000; endproperty
  a_hold: assert property (p_hold) else $error("count runs while stopped");
  property p_pend; interval_irq_o && !interval_ack_i |=> interval_irq_o; endproperty
  a_pend: assert property (p_pend) else $error("pending request lost");
  // the byte is reset to zero, so only compare once an edge out of reset has loaded it
  property p_cfg; !$past(reset_i) && $stable(alt_load_switch_i) |-> config_byte_o == {7'h00, alt_load_switch_i}; endproperty
  a_cfg: assert property (p_cfg) else $error("config flag wrong");
endmodule
bind rwt_restart_timer rwt_chk u_rwt_chk (.*);

// File: tb/rwt_host.sv
// rwt_host: processor model issuing i/o commands and taking interrupts.
// assumes commands launch on the falling edge of mclk_i.
`timescale 1ns/100ps
module rwt_host (
  input wire logic mclk_i,
  input wire logic irq_en_i,
  input wire logic interval_irq_i,
  output logic io_out_o,
  output logic io_start_mode_o,
  output logic io_status_rd_o,
  output logic [11:0] io_dev_addr_o,
  output logic interval_ack_o
);
  initial begin
    {io_out_o, io_start_mode_o, io_status_rd_o} = 3'h0;
    io_dev_addr_o = 12'h000;
  end
  // kind 0 status read, 1 stop, 2 start; one-cycle strobe
  task automatic io(input logic [1:0] k, input logic [11:0] a);
    @(negedge mclk_i);
    io_dev_addr_o = a;
    io_status_rd_o = k == 2'h0;
    io_out_o = k != 2'h0;
    io_start_mode_o = k == 2'h2;
    @(negedge mclk_i);
    {io_out_o, io_start_mode_o, io_status_rd_o} = 3'h0;
    io_dev_addr_o = ~a; // a released bus must not keep the old address
  endtask
  // the processor takes the request only while interrupts are allowed
  always @(negedge mclk_i) interval_ack_o <= interval_irq_i && irq_en_i;
endmodule

// File: tb/test_restart_watchdog_interval_timer.sv
// test_restart_watchdog_interval_timer: self-checking bench for rwt_restart_timer.
// assumes rwt_host plays the processor; pins change on the falling edge.
`timescale 1ns/100ps
module test_restart_watchdog_interval_timer;
  logic mclk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, kbd_clear_i = 1'b0, console_stop_i = 1'b0;
  logic console_single_i = 1'b0, manual_disable_i = 1'b0, interval_enable_i = 1'b0, boot_button_i = 1'b0;
  logic warn_patch_i = 1'b0, dual_boot_patch_i = 1'b0, load_source_switch_i = 1'b0, alt_load_switch_i = 1'b1;
  logic irq_en = 1'b1;
  logic [1:0] power_status_i = 2'h0, alt_subchan_i = 2'h3;
  logic [2:0] alt_port_i = 3'h7; // port 7 must clamp to 6
  wire logic io_out_i, io_start_mode_i, io_status_rd_i, interval_ack_i, status_valid_o, stop_line_o;
  wire logic io_reset_o, cpu_reset_o, boot_start_o, boot_remote_o, warn_irq_o, interval_irq_o, timer_running_o;
  wire logic [11:0] io_dev_addr_i;
  wire logic [1:0] status_data_o;
  wire logic [4:0] load_addr_o;
  wire logic [7:0] config_byte_o;
  wire logic [9:0] count_o;
  int n_errors = 0, comparisons = 0, i;
  // rows: {valid expected, kind, power lines, address}
  logic [16:0] rows [8] = '{17'h11DF0, 17'h12DF0, 17'h13DF0, 17'h00DF1, 17'h010F0, 17'h02DE0, 17'h04DF0, 17'h08DF0};
  rwt_restart_timer u_rwt_restart_timer (.*);
  rwt_host u_rwt_host (.mclk_i(mclk_i), .irq_en_i(irq_en), .interval_irq_i(interval_irq_o), .io_out_o(io_out_i),
    .io_start_mode_o(io_start_mode_i), .io_status_rd_o(io_status_rd_i), .io_dev_addr_o(io_dev_addr_i),
    .interval_ack_o(interval_ack_i));
  initial forever #20 mclk_i = ~mclk_i;
  task chk(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // n keyboard strobes, spaced wide enough for the pin synchroniser
  task kp(input int n);
    repeat (n) begin
      repeat (5) @(negedge mclk_i);
      kbd_clear_i = 1'b1;
      repeat (5) @(negedge mclk_i);
      kbd_clear_i = 1'b0;
    end
    repeat (6) @(negedge mclk_i);
  endtask
  // bounded wait for a boot start pulse
  task wb;
    for (int k = 0; k < 20 && boot_start_o !== 1'b1; k++) @(negedge mclk_i);
    chk(boot_start_o, 1);
    if (boot_start_o !== 1'b1) stop_test; // bound used up: report and end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge mclk_i);
    chk(config_byte_o, 0);
    reset_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(count_o, 0);
    chk(timer_running_o, 1);
    chk(config_byte_o, 8'h01);
    chk(load_addr_o, 0);
    $display("reset test done");
    foreach (rows[i]) begin
      power_status_i = rows[i][13:12];
      repeat (6) @(negedge mclk_i);
      u_rwt_host.io(rows[i][15:14], rows[i][11:0]);
      chk(status_valid_o, rows[i][16]);
      if (rows[i][16]) chk(status_data_o, rows[i][13:12]);
    end
    $display("row test done");
    kp(3);
    chk(count_o, 3);
    for (i = 0; i < 3; i++) begin
      {console_single_i, console_stop_i, manual_disable_i} = 3'h1 << i;
      kp(2);
      chk(count_o, 0);
      chk(stop_line_o, i > 0);
      {console_single_i, console_stop_i, manual_disable_i} = 3'h0;
      kp(1);
      chk(count_o, 1);
    end
    u_rwt_host.io(2'h1, 12'hDF0);
    kp(2);
    chk(count_o, 0);
    chk(timer_running_o, 0);
    u_rwt_host.io(2'h2, 12'hDF0);
    kp(1);
    chk(count_o, 1);
    $display("disable test done");
    chk(interval_irq_o, 0);
    irq_en = 1'b0;
    interval_enable_i = 1'b1;
    kp(2);
    chk(interval_irq_o, 1);
    irq_en = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk(interval_irq_o, 0);
    console_stop_i = 1'b1;
    kp(1);
    chk(interval_irq_o, 0);
    console_stop_i = 1'b0;
    interval_enable_i = 1'b0;
    $display("interval test done");
    warn_patch_i = 1'b1;
    u_rwt_host.io(2'h0, 12'hDF0);
    kp(255);
    chk(warn_irq_o, 0);
    kp(1);
    chk(warn_irq_o, 1);
    kp(255);
    chk(count_o, 10'h1FF);
    kbd_clear_i = 1'b1;
    wb;
    chk(io_reset_o, 1);
    chk(cpu_reset_o, 1);
    kbd_clear_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(count_o, 0);
    chk(boot_remote_o, 0);
    chk(load_addr_o, 5'h1B);
    $display("timeout test done");
    dual_boot_patch_i = 1'b1;
    u_rwt_host.io(2'h1, 12'hDF0);
    wb;
    @(negedge mclk_i);
    chk(boot_remote_o, 1);
    for (i = 0; i < 2; i++) begin
      load_source_switch_i = i[0];
      boot_button_i = 1'b1;
      wb;
      boot_button_i = 1'b0;
      // the button must sit low long enough for the synchroniser to agree
      repeat (6) @(negedge mclk_i);
      chk(boot_remote_o, i[0]);
    end
    $display("boot test done");
    u_rwt_host.io(2'h2, 12'hDF0);
    kp(2);
    chk(count_o, 2);
    // with the enable low a strobe must leave no trace at all
    clk_en_i = 1'b0;
    kp(2);
    chk(count_o, 2);
    clk_en_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk(count_o, 2);
    // second reset in mid-run
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(count_o, 0);
    chk(load_addr_o, 0);
    reset_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(timer_running_o, 1);
    chk(config_byte_o, 8'h01);
    $display("reset and freeze test done");
    stop_test;
  end
endmodule
